// ---- common/pwl_consts.svh ----
// constants of the piecewise-linear lookup evaluator
`ifndef PWL_CONSTS_SVH
`define PWL_CONSTS_SVH
`define PWL_MAX_POINTS  48
`define PWL_ERR_CODE    16'h1004
`define PWL_EXP_SPECIAL 8'hFF
`define PWL_EXP_BIAS    11'sd127
`define PWL_ZERO_WORD   32'h0000_0000
`define PWL_OUT_RESET   32'h0000_0000
`define PWL_ALU_STEPS   5
`endif

// ---- common/pwl_pkg.sv ----
// types shared by the piecewise-linear lookup evaluator
`include "pwl_consts.svh"
package pwl_pkg;
   typedef enum logic [3:0] {
      PWL_IDLE  = 4'h0,
      PWL_CHECK = 4'h1,
      PWL_SCAN  = 4'h2,
      PWL_DR    = 4'h3,
      PWL_DE    = 4'h4,
      PWL_MUL   = 4'h5,
      PWL_DS    = 4'h6,
      PWL_DIV   = 4'h7,
      PWL_ADD   = 4'h8
   } pwl_state_t;

   typedef enum logic [1:0] {
      PWL_OP_ADD = 2'h0,
      PWL_OP_SUB = 2'h1,
      PWL_OP_MUL = 2'h2,
      PWL_OP_DIV = 2'h3
   } pwl_op_t;

   typedef struct packed {
      pwl_state_t                          st;
      logic [5:0]                          idx;
      logic [15:0]                         cnt;
      logic [31:0]                         inVal;
      logic                                inv;
      logic [31:0]                         t1;
      logic [31:0]                         t2;
      logic [31:0]                         outVal;
      logic                                done;
      logic                                err;
      logic [`PWL_MAX_POINTS-1:0][31:0]    tabX;
      logic [`PWL_MAX_POINTS-1:0][31:0]    tabY;
   } pwl_regs_t;
endpackage

// ---- design/pwl_fpu.sv ----
// single-precision add, subtract, multiply and divide, combinational
`timescale 1ns/10ps
`default_nettype none
`include "pwl_consts.svh"
module pwl_fpu
   import pwl_pkg::*;
(
   input  wire logic [31:0] opA,
   input  wire logic [31:0] opB,
   input  wire pwl_op_t     op,
   output logic [31:0]      result,
   output logic             fault
);
   // truncating rounding and flush-to-zero keep the unit small
   logic               sA;
   logic               sB;
   logic               sR;
   logic [7:0]         eA;
   logic [7:0]         eB;
   logic [23:0]        mA;
   logic [23:0]        mB;
   logic signed [10:0] eR;
   logic [22:0]        fR;
   logic [24:0]        sum;
   logic [47:0]        prod;
   logic [47:0]        quot;
   logic [7:0]         dif;
   logic [4:0]         lz;

   always_comb begin
      sA   = opA[31];
      sB   = opB[31] ^ (op == PWL_OP_SUB);
      eA   = opA[30:23];
      eB   = opB[30:23];
      mA   = (eA == 8'h00) ? 24'h00_0000 : {1'b1, opA[22:0]};
      mB   = (eB == 8'h00) ? 24'h00_0000 : {1'b1, opB[22:0]};
      sR   = 1'b0;
      eR   = 11'sd0;
      fR   = 23'h00_0000;
      sum  = 25'h000_0000;
      prod = 48'h0000_0000_0000;
      quot = 48'h0000_0000_0000;
      dif  = 8'h00;
      lz   = 5'h00;
      fault = (eA == `PWL_EXP_SPECIAL) || (eB == `PWL_EXP_SPECIAL);
      unique case (op)
         PWL_OP_ADD, PWL_OP_SUB: begin
            if ({eB, mB} > {eA, mA}) begin
               {sA, sB} = {sB, sA};
               {eA, eB} = {eB, eA};
               {mA, mB} = {mB, mA};
            end
            dif = eA - eB;
            mB  = (dif > 8'h18) ? 24'h00_0000 : (mB >> dif);
            sum = (sA == sB) ? ({1'b0, mA} + {1'b0, mB}) : ({1'b0, mA} - {1'b0, mB});
            sR  = sA;
            if (sum[24]) begin
               fR = sum[23:1];
               eR = $signed({3'b000, eA}) + 11'sd1;
            end else begin
               for (int k = 0; k < 24; k++) begin
                  if (sum[k]) begin
                     lz = 5'(23 - k);
                  end
               end
               sum = sum << lz;
               fR  = sum[22:0];
               eR  = $signed({3'b000, eA}) - $signed({6'b00_0000, lz});
               if (!sum[23]) begin
                  eR = 11'sd0;
               end
            end
         end
         PWL_OP_MUL: begin
            sR   = sA ^ sB;
            prod = {24'h00_0000, mA} * {24'h00_0000, mB};
            eR   = $signed({3'b000, eA}) + $signed({3'b000, eB}) - `PWL_EXP_BIAS;
            if (prod[47]) begin
               fR = prod[46:24];
               eR = eR + 11'sd1;
            end else begin
               fR = prod[45:23];
            end
            if (mA == 24'h00_0000 || mB == 24'h00_0000) begin
               eR = 11'sd0;
            end
         end
         PWL_OP_DIV: begin
            sR = sA ^ sB;
            if (mB == 24'h00_0000) begin
               fault = 1'b1;
            end else begin
               quot = {mA, 24'h00_0000} / {24'h00_0000, mB};
            end
            if (quot[24]) begin
               fR = quot[23:1];
               eR = $signed({3'b000, eA}) - $signed({3'b000, eB}) + `PWL_EXP_BIAS;
            end else begin
               fR = quot[22:0];
               eR = $signed({3'b000, eA}) - $signed({3'b000, eB}) + `PWL_EXP_BIAS - 11'sd1;
            end
            if (mA == 24'h00_0000) begin
               eR = 11'sd0;
            end
         end
      endcase
      if (eR >= 11'sd255) begin
         fault = 1'b1;
      end
      if (eR <= 11'sd0) begin
         result = `PWL_ZERO_WORD;
      end else begin
         result = {sR, eR[7:0], fR};
      end
   end
endmodule
`default_nettype wire

// ---- design/pwl_lookup.sv ----
// piecewise-linear forward and inverse lookup with its point table
//
// Overview of operation
// - forward mode clamps to first/last y outside table, interpolates y between x points.
// - inverse mode clamps to first/last x outside table, interpolates x between y points.
// - a point count of zero ends evaluation with the output left unchanged.
// - a searched coordinate below its predecessor truncates the table at the predecessor.
// - among equal searched coordinates the lowest index point decides the output.
// - a point count below zero or above 48 gives error 4100, no evaluation.
// - an arithmetic fault during evaluation gives error 4100.
// - inverse mode returns the x matching the input along the point pattern.
`timescale 1ns/10ps
`default_nettype none
`include "pwl_consts.svh"
module pwl_lookup
   import pwl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        startEval,
   input  wire logic        inverseLookupMode,
   input  wire logic [31:0] inputValue,
   input  wire logic [15:0] pointCount,
   input  wire logic        tabWrEn,
   input  wire logic [5:0]  tabWrIndex,
   input  wire logic [31:0] abscissaPoint,
   input  wire logic [31:0] ordinatePoint,
   output logic [31:0]      outputValue,
   output logic             evalBusy,
   output logic             evalDone,
   output logic             evalError,
   output logic [15:0]      errorCode
);
   pwl_regs_t   r;
   pwl_regs_t   next_r;
   logic [31:0] sCur;
   logic [31:0] sPrev;
   logic [31:0] rCur;
   logic [31:0] rPrev;
   logic [5:0]  prevIdx;
   logic [31:0] aluA;
   logic [31:0] aluB;
   pwl_op_t     aluOp;
   logic [31:0] aluRes;
   logic        aluFault;
   logic        aluState;
   logic        badCount;
   logic        scanEnd;
   logic        scanTrunc;
   logic        scanHit;

   function automatic logic [31:0] pick(
      input logic [`PWL_MAX_POINTS-1:0][31:0] tx,
      input logic [`PWL_MAX_POINTS-1:0][31:0] ty,
      input logic                             useY,
      input logic [5:0]                       i);
      if (i >= 6'(`PWL_MAX_POINTS)) begin
         return `PWL_ZERO_WORD;
      end
      return useY ? ty[i] : tx[i];
   endfunction

   // maps a float onto an unsigned key that orders like the real value
   function automatic logic [31:0] fkey(input logic [31:0] x);
      return x[31] ? ~x : (x | 32'h8000_0000);
   endfunction

   function automatic logic fle(input logic [31:0] a, input logic [31:0] b);
      return fkey(a) <= fkey(b);
   endfunction

   always_comb begin
      prevIdx   = (r.idx == 6'h00) ? 6'h00 : r.idx - 6'h01;
      sCur      = pick(r.tabX, r.tabY, r.inv, r.idx);
      sPrev     = pick(r.tabX, r.tabY, r.inv, prevIdx);
      rCur      = pick(r.tabX, r.tabY, !r.inv, r.idx);
      rPrev     = pick(r.tabX, r.tabY, !r.inv, prevIdx);
      badCount  = $signed(r.cnt) < 0 || r.cnt > 16'(`PWL_MAX_POINTS);
      scanEnd   = {10'h000, r.idx} >= r.cnt;
      scanTrunc = !fle(sPrev, sCur);
      scanHit   = fle(r.inVal, sCur);
      aluState  = r.st inside {PWL_DR, PWL_DE, PWL_MUL, PWL_DS, PWL_DIV, PWL_ADD};
   end

   // operand steering: (dr * de) / ds + rPrev, one float operation per cycle
   always_comb begin
      aluA  = r.t1;
      aluB  = r.t2;
      aluOp = PWL_OP_SUB;
      unique case (r.st)
         PWL_DR: begin
            aluA = rCur;
            aluB = rPrev;
         end
         PWL_DE: begin
            aluA = r.inVal;
            aluB = sPrev;
         end
         PWL_MUL: aluOp = PWL_OP_MUL;
         PWL_DS: begin
            aluA = sCur;
            aluB = sPrev;
         end
         PWL_DIV: aluOp = PWL_OP_DIV;
         PWL_ADD: begin
            aluB  = rPrev;
            aluOp = PWL_OP_ADD;
         end
         default: aluOp = PWL_OP_SUB;
      endcase
   end

   pwl_fpu u_fpu (
      .opA    (aluA),
      .opB    (aluB),
      .op     (aluOp),
      .result (aluRes),
      .fault  (aluFault)
   );

   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      unique case (r.st)
         PWL_IDLE: begin
            // the table is frozen while an evaluation walks it
            if (tabWrEn && tabWrIndex < 6'(`PWL_MAX_POINTS)) begin
               next_r.tabX[tabWrIndex] = abscissaPoint;
               next_r.tabY[tabWrIndex] = ordinatePoint;
            end
            if (startEval) begin
               next_r.st    = PWL_CHECK;
               next_r.idx   = 6'h00;
               next_r.cnt   = pointCount;
               next_r.inVal = inputValue;
               next_r.inv   = inverseLookupMode;
               next_r.err   = 1'b0;
            end
         end
         PWL_CHECK: begin
            next_r.st   = PWL_IDLE;
            next_r.done = 1'b1;
            if (badCount) begin
               next_r.err = 1'b1;
            end else if (r.cnt == 16'h0000) begin
               next_r.err = 1'b0;
            end else if (r.inVal[30:23] == `PWL_EXP_SPECIAL ||
                         sCur[30:23] == `PWL_EXP_SPECIAL) begin
               next_r.err = 1'b1;
            end else if (scanHit) begin
               next_r.outVal = rCur;
            end else begin
               next_r.st   = PWL_SCAN;
               next_r.idx  = 6'h01;
               next_r.done = 1'b0;
            end
         end
         PWL_SCAN: begin
            if (scanEnd || scanTrunc) begin
               next_r.outVal = rPrev;
               next_r.st     = PWL_IDLE;
               next_r.done   = 1'b1;
            end else if (scanHit) begin
               // first hit wins; strictly rising pair so ds is never zero
               next_r.st = PWL_DR;
            end else begin
               next_r.idx = r.idx + 6'h01;
            end
         end
         PWL_DR: begin
            next_r.t1 = aluRes;
            next_r.st = PWL_DE;
         end
         PWL_DE: begin
            next_r.t2 = aluRes;
            next_r.st = PWL_MUL;
         end
         PWL_MUL: begin
            next_r.t1 = aluRes;
            next_r.st = PWL_DS;
         end
         PWL_DS: begin
            next_r.t2 = aluRes;
            next_r.st = PWL_DIV;
         end
         PWL_DIV: begin
            next_r.t1 = aluRes;
            next_r.st = PWL_ADD;
         end
         PWL_ADD: begin
            next_r.outVal = aluRes;
            next_r.st     = PWL_IDLE;
            next_r.done   = 1'b1;
         end
         default: next_r.st = PWL_IDLE;
      endcase
      // a fault abandons the evaluation and keeps the old output
      if (aluState && aluFault) begin
         next_r.outVal = r.outVal;
         next_r.err    = 1'b1;
         next_r.done   = 1'b1;
         next_r.st     = PWL_IDLE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r        <= '0;
         r.st     <= PWL_IDLE;
         r.outVal <= `PWL_OUT_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign outputValue = r.outVal;
   assign evalBusy    = r.st != PWL_IDLE;
   assign evalDone    = r.done;
   assign evalError   = r.err;
   assign errorCode   = r.err ? `PWL_ERR_CODE : 16'h0000;

   a_zero_count: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_IDLE && startEval && pointCount == 16'h0000) |->
         ##1 $stable(outputValue) ##1 ($stable(outputValue) && evalDone && !evalError))
      else $error("zero point count changed the output");

   a_bad_count: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_IDLE && startEval && ($signed(pointCount) < 0 || pointCount > 16'h0030))
         |-> ##2 (evalDone && evalError && errorCode == `PWL_ERR_CODE))
      else $error("bad point count not flagged");

   a_low_clamp: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_CHECK && !badCount && r.cnt != 16'h0000 && !evalError && scanHit &&
       r.inVal[30:23] != `PWL_EXP_SPECIAL && sCur[30:23] != `PWL_EXP_SPECIAL)
         |=> (evalDone && outputValue == $past(rCur)))
      else $error("low clamp value wrong");

   a_high_clamp: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_SCAN && scanEnd) |=> (evalDone && outputValue == $past(rPrev)))
      else $error("high clamp value wrong");

   a_cut_table: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_SCAN && !scanEnd && scanTrunc) |=> outputValue == $past(rPrev))
      else $error("falling point did not truncate");

   a_lowest_index: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_SCAN && !scanEnd && !scanTrunc && scanHit)
         |=> (r.st == PWL_DR && $stable(r.idx)))
      else $error("search went past the first hit");

   a_no_zero_div: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_DIV) |-> (r.t2[30:23] != 8'h00 && !$past(aluFault)))
      else $error("divide by zero reached");

   a_fault_code: assert property (@(posedge clk) disable iff (!arst_n)
      (aluState && aluFault) |=> (evalDone && errorCode == `PWL_ERR_CODE &&
         $stable(outputValue) && !evalBusy))
      else $error("fault not reported");

   a_one_update: assert property (@(posedge clk) disable iff (!arst_n)
      $changed(outputValue) |-> (evalDone && !evalError && $past(evalBusy)))
      else $error("output changed outside an evaluation end");

   a_interp_time: assert property (@(posedge clk) disable iff (!arst_n)
      (r.st == PWL_DR) |-> ##[1:6] evalDone)
      else $error("interpolation did not finish in time");
endmodule
`default_nettype wire

// ---- testbench/piecewise_linear_lookup_tb.sv ----
// self-checking testbench of the piecewise-linear lookup evaluator
`timescale 1ns/10ps
`default_nettype none
module piecewise_linear_lookup_tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        startEval;
   logic        inverseLookupMode;
   logic [31:0] inputValue;
   logic [15:0] pointCount;
   logic        tabWrEn;
   logic [5:0]  tabWrIndex;
   logic [31:0] abscissaPoint;
   logic [31:0] ordinatePoint;
   logic [31:0] outputValue;
   logic        evalBusy;
   logic        evalDone;
   logic        evalError;
   logic [15:0] errorCode;
   int          failures = 0;
   int          nChecks = 0;
   logic [31:0] lastOut = 32'h0000_0000;

   always #2 clk = ~clk;

   pwl_ctrl_model ctrl_u (
      .clk(clk), .startEval(startEval), .inverseLookupMode(inverseLookupMode),
      .inputValue(inputValue), .pointCount(pointCount), .tabWrEn(tabWrEn),
      .tabWrIndex(tabWrIndex), .abscissaPoint(abscissaPoint), .ordinatePoint(ordinatePoint)
   );

   pwl_lookup dut_u (
      .clk(clk), .arst_n(arst_n), .startEval(startEval),
      .inverseLookupMode(inverseLookupMode), .inputValue(inputValue),
      .pointCount(pointCount), .tabWrEn(tabWrEn), .tabWrIndex(tabWrIndex),
      .abscissaPoint(abscissaPoint), .ordinatePoint(ordinatePoint),
      .outputValue(outputValue), .evalBusy(evalBusy), .evalDone(evalDone),
      .evalError(evalError), .errorCode(errorCode)
   );

   task automatic summarize();
      $display("checks %0d, mismatches %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkBit(input string what, input logic exp, input logic got);
      nChecks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one request, bounded wait for the done pulse, then the pulse must be gone
   task automatic runEval(input logic inv, input logic [31:0] e, input logic [15:0] n);
      int k;
      ctrl_u.request(inv, e, n);
      chkBit("busy after start", 1'b1, evalBusy);
      for (k = 0; k < 80 && evalDone !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      if (evalDone !== 1'b1) begin
         failures++;
         $display("mismatch done expected 1 seen timeout");
         summarize();
      end
      chkBit("busy at done", 1'b0, evalBusy);
      @(posedge clk);
      #1;
      chkBit("single done", 1'b0, evalDone);
   endtask

   // ok evaluation: value and no error
   task automatic expectOk(input logic [31:0] exp);
      chkVal("output", exp, outputValue);
      chkBit("error", 1'b0, evalError);
      lastOut = exp;
   endtask

   task automatic scenReset();
      chkVal("output at reset", 32'h0000_0000, outputValue);
      chkBit("busy at reset", 1'b0, evalBusy);
      chkBit("error at reset", 1'b0, evalError);
   endtask

   // points (1,10) (3,30) (5,20): y falls at the last point
   task automatic scenForward();
      ctrl_u.writePoint(6'h00, 32'h3F80_0000, 32'h4120_0000);
      ctrl_u.writePoint(6'h01, 32'h4040_0000, 32'h41F0_0000);
      ctrl_u.writePoint(6'h02, 32'h40A0_0000, 32'h41A0_0000);
      runEval(1'b0, 32'h0000_0000, 16'h0003);
      expectOk(32'h4120_0000);
      runEval(1'b0, 32'h4000_0000, 16'h0003);
      expectOk(32'h41A0_0000);
      runEval(1'b0, 32'h4040_0000, 16'h0003);
      expectOk(32'h41F0_0000);
      runEval(1'b0, 32'h4080_0000, 16'h0003);
      expectOk(32'h41C8_0000);
      runEval(1'b0, 32'h40C0_0000, 16'h0003);
      expectOk(32'h41A0_0000);
   endtask

   // y sequence 10,30,20 cuts the inverse table at two points
   task automatic scenInverse();
      runEval(1'b1, 32'h40A0_0000, 16'h0003);
      expectOk(32'h3F80_0000);
      runEval(1'b1, 32'h41A0_0000, 16'h0003);
      expectOk(32'h4000_0000);
      runEval(1'b1, 32'h4220_0000, 16'h0003);
      expectOk(32'h4040_0000);
   endtask

   // zero, out-of-range and boundary counts
   task automatic scenCount();
      runEval(1'b0, 32'h4000_0000, 16'h0000);
      expectOk(lastOut);
      runEval(1'b0, 32'h4000_0000, 16'h0031);
      chkBit("error", 1'b1, evalError);
      chkVal("code", 32'h0000_1004, {16'h0000, errorCode});
      chkVal("output", lastOut, outputValue);
      runEval(1'b0, 32'h4000_0000, 16'hFFFF);
      chkBit("error", 1'b1, evalError);
      chkVal("code", 32'h0000_1004, {16'h0000, errorCode});
      // unwritten points are zero, so the x scan cuts at three points
      runEval(1'b0, 32'h40C0_0000, 16'h0030);
      expectOk(32'h41A0_0000);
      chkVal("code cleared", 32'h0000_0000, {16'h0000, errorCode});
   endtask

   task automatic scenFault();
      runEval(1'b0, 32'h7FC0_0000, 16'h0003);
      chkBit("error", 1'b1, evalError);
      chkVal("code", 32'h0000_1004, {16'h0000, errorCode});
      chkVal("output", lastOut, outputValue);
   endtask

   // x sequence 1,1,5: the lowest index wins and nothing divides by zero
   task automatic scenEqual();
      ctrl_u.writePoint(6'h01, 32'h3F80_0000, 32'h4248_0000);
      runEval(1'b0, 32'h3F80_0000, 16'h0003);
      expectOk(32'h4120_0000);
      runEval(1'b0, 32'h4040_0000, 16'h0003);
      expectOk(32'h420C_0000);
   endtask

   // a huge last y makes the product overflow: error reported, output kept
   task automatic scenOverflow();
      ctrl_u.writePoint(6'h02, 32'h40A0_0000, 32'h7F00_0000);
      runEval(1'b0, 32'h4040_0000, 16'h0003);
      chkBit("error", 1'b1, evalError);
      chkVal("code", 32'h0000_1004, {16'h0000, errorCode});
      chkVal("output", lastOut, outputValue);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      scenReset();
      scenForward();
      scenInverse();
      scenCount();
      scenFault();
      scenEqual();
      scenOverflow();
      summarize();
   end
endmodule
`default_nettype wire

// ---- testbench/pwl_ctrl_model.sv ----
// controller model: loads the point table and issues evaluation requests
`timescale 1ns/10ps
`default_nettype none
module pwl_ctrl_model (
   input  wire logic   clk,
   output logic        startEval,
   output logic        inverseLookupMode,
   output logic [31:0] inputValue,
   output logic [15:0] pointCount,
   output logic        tabWrEn,
   output logic [5:0]  tabWrIndex,
   output logic [31:0] abscissaPoint,
   output logic [31:0] ordinatePoint
);
   initial begin
      startEval = 1'b0;
      inverseLookupMode = 1'b0;
      inputValue = 32'h0000_0000;
      pointCount = 16'h0000;
      tabWrEn = 1'b0;
      tabWrIndex = 6'h00;
      abscissaPoint = 32'h0000_0000;
      ordinatePoint = 32'h0000_0000;
   end

   // x and y of one point travel in one strobe
   task automatic writePoint(input logic [5:0] idx, input logic [31:0] x, input logic [31:0] y);
      @(posedge clk);
      #1;
      tabWrEn = 1'b1;
      tabWrIndex = idx;
      abscissaPoint = x;
      ordinatePoint = y;
      @(posedge clk);
      #1;
      tabWrEn = 1'b0;
      // released lines must not keep showing the old value
      abscissaPoint = ~x;
      ordinatePoint = ~y;
   endtask

   // caller only starts while the evaluator is idle
   task automatic request(input logic inv, input logic [31:0] e, input logic [15:0] n);
      @(posedge clk);
      #1;
      startEval = 1'b1;
      inverseLookupMode = inv;
      inputValue = e;
      pointCount = n;
      @(posedge clk);
      #1;
      startEval = 1'b0;
      inputValue = ~e;
      pointCount = ~n;
   endtask
endmodule
`default_nettype wire
